// ---- prd_bank.sv ----
/*
 * Peripheral register bank with per-reset-class initial values,
 * wake-up flag setting, vectoring and stack push, reached over APB.
 * Assumes presetn is the power-on/brown-out reset and that the core
 * raises one-cycle pulses for the watchdog, instruction and stack resets and for wake-up.
 */
`timescale 1ns/1ps

module prd_bank
    import prd_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset sources other than power-on
    input wire logic external_reset_pin_n,
    input wire logic wdt_reset,
    input wire logic reset_instr,
    input wire logic stack_reset,
    // Configuration and pins
    input wire logic [2:0] osc_mode,
    input wire logic [7:0] port_a_pins,
    // Wake-up from sleep
    input wire prd_wake_s wake,
    input wire logic [PC_W-1:0] current_pc,
    output prd_vector_s vector_out,
    output prd_push_s push_out,
    // Register contents toward the peripherals
    output logic [NREG-1:0][7:0] reg_image
);

    // ************************************************************
    // Reset classification
    // ************************************************************
    logic pin_stable;
    logic [7:0] pins_stable;
    logic warm_rst;
    logic wake_evt;
    logic pulse_rst;
    logic pin_rst;

    // Starts released, so power-on leaves no warm reset behind
    prd_sync #(.W(1), .INIT(1'b1)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(external_reset_pin_n),
        .stable(pin_stable)
    );

    // Pins are only seen through the filter, never raw
    prd_sync #(.W(8), .INIT(8'h00)) u_port_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(port_a_pins),
        .stable(pins_stable)
    );

    // Core pulses are one cycle wide and already in the pclk domain
    assign pulse_rst = wdt_reset || reset_instr || stack_reset;
    // The pin reset acts as a level for as long as it is held low
    assign pin_rst = !pin_stable;
    assign warm_rst = pin_rst || pulse_rst;
    // A reset in the same cycle as a wake-up takes precedence
    assign wake_evt = wake.valid && !warm_rst;

    // ************************************************************
    // APB decode
    // ************************************************************
    logic [ADDR_W-3:0] idx;
    logic mapped;
    logic wr_en;
    logic setup;
    logic aligned;
    logic stored;

    assign idx = paddr[ADDR_W-1:2];
    assign aligned = paddr[1:0] == 2'h0;
    assign stored = int'(idx) < NREG;
    assign mapped = aligned && (int'(idx) <= IDX_LAST);
    assign setup = psel && !penable;
    // Writes land at the access edge; pready is high there by design.
    // Read-only views decode as mapped but have no cell to write.
    assign wr_en = psel && penable && pready && pwrite && mapped &&
                   stored && pstrb[0];

    // ************************************************************
    // Wake flag selection
    // ************************************************************
    logic [NREG-1:0][7:0] wake_set;
    logic [7:0] flag_onehot;

    always_comb begin
        wake_set = '0;
        flag_onehot = 8'h01 << wake.flag_bit;
        if (wake_evt) begin
            case (wake.flag_reg)
                FLAG_CORE: wake_set[IDX_CORE_IRQ] = flag_onehot;
                FLAG_REQ_ONE: wake_set[IDX_REQ_ONE] = flag_onehot;
                FLAG_REQ_TWO: wake_set[IDX_REQ_TWO] = flag_onehot;
                FLAG_REQ_THREE: wake_set[IDX_REQ_THREE] = flag_onehot;
                default: wake_set = '0;
            endcase
        end
    end

    // ************************************************************
    // Register storage
    // ************************************************************
    // Each entry is steered by its own masks; the same generic cell
    // carries every reset class, so the table is the only place the
    // per-register reset behaviour lives.
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            logic [7:0] q;
            logic [7:0] next_q;

            always_comb begin
                next_q = q;
                // Unimplemented bits are dropped as written
                if (wr_en && int'(idx) == gi) begin
                    next_q = pwdata[7:0] & IMPL_MASK[gi];
                end
                if (warm_rst) begin
                    next_q = (next_q & ~WARM_MASK[gi]) |
                             (RST_VAL[gi] & WARM_MASK[gi]);
                end else if (wake_evt) begin
                    next_q = (next_q & ~WAKE_MASK[gi]) |
                             (RST_VAL[gi] & WAKE_MASK[gi]);
                end
                // Hardware set wins over a software clear in the same cycle
                next_q = next_q | (wake_set[gi] & IMPL_MASK[gi]);
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q <= RST_VAL[gi];
                end else begin
                    q <= next_q;
                end
            end

            assign reg_image[gi] = q;
        end
    endgenerate

    // ************************************************************
    // Wake-up vectoring and stack push
    // ************************************************************
    logic irq_vectors;
    logic [7:0] core_irq;
    logic [SP_W-1:0] stack_pointer_reg;
    logic [SP_W-1:0] next_sp;
    logic gie_sel;
    logic [PC_W-1:0] vec_target;

    assign core_irq = reg_image[IDX_CORE_IRQ];
    // Enables sampled before the wake flags land
    assign gie_sel = wake.high_prio ? core_irq[BIT_HIGH_PRIO_GIE]
                                    : core_irq[BIT_LOW_PRIO_GIE];
    assign irq_vectors = wake_evt && wake.by_irq && gie_sel;
    assign vec_target = wake.high_prio ? VEC_HIGH : VEC_LOW;

    // Target held until the next interrupt wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_out <= '0;
        end else begin
            vector_out.load <= irq_vectors;
            if (irq_vectors) begin
                vector_out.pc <= vec_target;
            end
        end
    end

    // Stack pointer wraps past its top; overflow handling is the core's
    always_comb begin
        next_sp = stack_pointer_reg;
        if (warm_rst) begin
            next_sp = '0;
        end else if (irq_vectors) begin
            next_sp = stack_pointer_reg + SP_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer_reg <= '0;
        end else begin
            stack_pointer_reg <= next_sp;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            push_out <= '0;
        end else begin
            push_out.push <= irq_vectors;
            push_out.stack_pointer_reg <= next_sp;
            if (irq_vectors) begin
                push_out.stack_top_upper <= current_pc[20:16];
                push_out.stack_top_high <= current_pc[15:8];
                push_out.stack_top_low <= current_pc[7:0];
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic shared_pin_io;
    logic [7:0] rd_byte;
    logic [31:0] rd_word;

    // Only two oscillator modes free the shared pin for I/O
    assign shared_pin_io = (osc_mode == OSC_EXT_CLOCK_IO) ||
                           (osc_mode == OSC_RC_IO);

    always_comb begin
        rd_byte = 8'h00;
        rd_word = 32'h0000_0000;
        if (stored) begin
            rd_byte = reg_image[idx];
        end
        case (int'(idx))
            IDX_PORT_A_LATCH, IDX_PORT_A_DIR: begin
                rd_byte[BIT_PORT_A_SHARED] = rd_byte[BIT_PORT_A_SHARED] &
                                             shared_pin_io;
            end
            IDX_PORT_A_PINS: begin
                rd_byte = pins_stable & 8'h7F;
                rd_byte[BIT_PORT_A_SHARED] = pins_stable[BIT_PORT_A_SHARED] &
                                             shared_pin_io;
            end
            IDX_STACK_PTR: begin
                rd_byte = {3'h0, stack_pointer_reg};
            end
            default: begin
                if (int'(idx) >= IDX_CAN_MIRROR_FIRST &&
                    int'(idx) <= IDX_CAN_MIRROR_LAST) begin
                    rd_byte = reg_image[IDX_CAN_STATUS];
                end
            end
        endcase
        if (int'(idx) == IDX_STACK_TOP) begin
            rd_word = {11'h000, push_out.stack_top_upper,
                       push_out.stack_top_high, push_out.stack_top_low};
        end else begin
            rd_word = {24'h00_0000, rd_byte};
        end
    end

    // Answer is prepared in setup so the first access cycle completes
    // A refused access still completes at once, with the error set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite && mapped) begin
                prdata <= rd_word;
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule

// ---- prd_bank_props.sv ----
/*
 * Port checker for the peripheral reset-defaults bank.
 * Bound onto prd_bank by the bench; sees only that module's ports.
 */
`timescale 1ns/1ps

module prd_bank_props
    import prd_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Reset sources
    input wire logic external_reset_pin_n,
    input wire logic wdt_reset,
    input wire logic reset_instr,
    input wire logic stack_reset,
    // Wake and image
    input wire prd_wake_s wake,
    input wire logic [PC_W-1:0] current_pc,
    input wire prd_vector_s vector_out,
    input wire prd_push_s push_out,
    input wire logic [NREG-1:0][7:0] reg_image
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ********
    // Helpers
    // ********
    // The pin reset lags its synchroniser, so a span around it is avoided
    logic [3:0] pin_quiet;
    logic pulse_d;
    logic pulse;
    logic warm;
    assign pulse = wdt_reset | reset_instr | stack_reset;
    assign warm = pulse | pulse_d | (pin_quiet < 4'h8);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_quiet <= 4'hF;
        end else if (!external_reset_pin_n) begin
            pin_quiet <= 4'h0;
        end else if (pin_quiet != 4'hF) begin
            pin_quiet <= pin_quiet + 4'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_d <= 1'b0;
        end else begin
            pulse_d <= pulse;
        end
    end

    sequence s_wake;
        wake.valid && !warm && !(psel && penable);
    endsequence
    sequence s_irq_wake;
        s_wake ##0 wake.by_irq && reg_image[IDX_CORE_IRQ][wake.high_prio ?
            BIT_HIGH_PRIO_GIE : BIT_LOW_PRIO_GIE];
    endsequence
    sequence s_warm;
        pulse && !psel ##1 !psel;
    endsequence

    // ********
    // Properties
    // ********
    AST_VEC_HIGH: assert property (s_irq_wake ##0 wake.high_prio |=>
        vector_out.load && vector_out.pc == VEC_HIGH)
        else $error("high vector not loaded");
    AST_VEC_LOW: assert property (s_irq_wake ##0 !wake.high_prio |=>
        vector_out.load && vector_out.pc == VEC_LOW)
        else $error("low vector not loaded");
    AST_NO_VEC: assert property (s_wake ##0 !wake.by_irq |=>
        !vector_out.load && !push_out.push)
        else $error("vector without interrupt");
    AST_PUSH_PC: assert property (s_irq_wake |=> push_out.push &&
        {push_out.stack_top_upper, push_out.stack_top_high,
        push_out.stack_top_low} == $past(current_pc))
        else $error("stack top not pushed");
    AST_FLAG_REQ: assert property (s_wake ##0
        wake.flag_reg == FLAG_REQ_ONE |=>
        reg_image[IDX_REQ_ONE][$past(wake.flag_bit)])
        else $error("wake flag missing");
    AST_ECC_WAKE: assert property (s_wake |=> reg_image[IDX_ECC_CONTROL] ==
        8'h00 && reg_image[IDX_ECC_DEADBAND] == 8'h00 &&
        reg_image[IDX_ECC_SHUTDOWN] == 8'h00)
        else $error("enhanced regs kept on wake");
    AST_PRIO_WARM: assert property (s_warm |=>
        reg_image[IDX_PRIO_ONE] == 8'hFF && reg_image[IDX_PRIO_THREE] == 8'hFF)
        else $error("priority one or three not set");
    AST_PRIO2_WARM: assert property (s_warm |=>
        reg_image[IDX_PRIO_TWO] == 8'h5F)
        else $error("priority two wrong");
    AST_TXSTAT_WARM: assert property (s_warm |=>
        reg_image[IDX_SER_TX_STAT] == 8'h02)
        else $error("transmit status wrong");
    AST_T3_KEEP: assert property (s_warm |=>
        reg_image[IDX_TMR3_CONTROL] == $past(reg_image[IDX_TMR3_CONTROL], 2))
        else $error("timer three control changed");
    AST_APB_ERR: assert property (psel && !penable && paddr[1:0] != 2'h0 |=>
        pready && pslverr)
        else $error("unaligned access accepted");
endmodule

// ---- prd_bank_tb.sv ----
/*
 * Self-checking bench for the reset-defaults bank.
 * Drives APB, reset sources, pins and wakes; needs prd_pkg and checker.
 */
`timescale 1ns/1ps

module prd_bank_tb
    import prd_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic external_reset_pin_n, wdt_reset, reset_instr, stack_reset;
    logic [7:0] paddr, port_a_pins;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] osc_mode;
    prd_wake_s wake;
    logic [PC_W-1:0] current_pc, top;
    prd_vector_s vector_out;
    prd_push_s push_out;
    logic [NREG-1:0][7:0] reg_image;
    logic [7:0] expv [NREG];
    logic [SP_W-1:0] sp;
    int err_count, check_count;
    int fidx [4] = '{IDX_CORE_IRQ, IDX_REQ_ONE, IDX_REQ_TWO, IDX_REQ_THREE};

    prd_bank i_prd_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .external_reset_pin_n,
        .wdt_reset, .reset_instr, .stack_reset, .osc_mode, .port_a_pins,
        .wake, .current_pc, .vector_out, .push_out, .reg_image);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk(n < 16, 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // CAN mirrors follow the stored image; pin, stack pointer and stack top views use their own models
    function automatic logic [31:0] exp_rd(input int i);
        logic [31:0] v;
        v = '0;
        if (i < NREG) v[7:0] = expv[i];
        else if (i <= IDX_CAN_MIRROR_LAST) v[7:0] = expv[IDX_CAN_STATUS];
        else if (i == IDX_PORT_A_PINS) v[7:0] = port_a_pins & 8'h7F;
        else if (i == IDX_STACK_PTR) v[SP_W-1:0] = sp;
        else v[PC_W-1:0] = top;
        if (osc_mode != OSC_EXT_CLOCK_IO && osc_mode != OSC_RC_IO &&
            (i == IDX_PORT_A_LATCH || i == IDX_PORT_A_DIR ||
            i == IDX_PORT_A_PINS)) v[BIT_PORT_A_SHARED] = 1'b0;
        return v;
    endfunction

    task automatic rd_chk(input int i);
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'(i * 4), 32'h0, r, e);
        chk(r, exp_rd(i));
        chk(e, 1'b0);
    endtask

    task automatic rd_all();
        for (int i = 0; i <= IDX_LAST; i++) rd_chk(i);
    endtask

    task automatic wr1(input int i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, 8'(i * 4), d, r, e);
        expv[i] = d[7:0] & IMPL_MASK[i];
    endtask

    task automatic wr_all();
        for (int i = 0; i < NREG; i++) wr1(i, $urandom);
    endtask

    task automatic restore(input logic [7:0] m [NREG]);
        foreach (expv[i]) expv[i] = (expv[i] & ~m[i]) | (RST_VAL[i] & m[i]);
    endtask

    task automatic warm(input int k);
        @(posedge pclk);
        case (k)
            0: wdt_reset <= 1'b1;
            1: reset_instr <= 1'b1;
            2: stack_reset <= 1'b1;
            default: external_reset_pin_n <= 1'b0;
        endcase
        @(posedge pclk);
        {wdt_reset, reset_instr, stack_reset} <= 3'h0;
        repeat (8) @(posedge pclk);
        external_reset_pin_n <= 1'b1;
        repeat (8) @(posedge pclk);
        restore(WARM_MASK);
        sp = '0;
    endtask

    task automatic wk(input prd_wake_s w);
        logic fire;
        fire = w.by_irq && expv[IDX_CORE_IRQ][w.high_prio ?
            BIT_HIGH_PRIO_GIE : BIT_LOW_PRIO_GIE];
        w.valid = 1'b1;
        @(posedge pclk);
        wake <= w;
        current_pc <= PC_W'($urandom);
        @(posedge pclk);
        wake.valid <= 1'b0;
        #1;
        chk(vector_out.load, fire);
        chk(push_out.push, fire);
        if (fire) begin
            sp++;
            top = current_pc;
            chk(vector_out.pc, w.high_prio ? VEC_HIGH : VEC_LOW);
            chk({push_out.stack_top_upper, push_out.stack_top_high,
                push_out.stack_top_low}, top);
            chk(push_out.stack_pointer_reg, sp);
        end
        restore(WAKE_MASK);
        expv[fidx[w.flag_reg]] |= (8'h01 << w.flag_bit) &
            IMPL_MASK[fidx[w.flag_reg]];
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        test_done();
    end

    initial begin
        logic [31:0] r;
        logic e;
        prd_wake_s w;
        void'($urandom(91844));
        presetn = 1'b0;
        {psel, penable, pwrite, wdt_reset, reset_instr, stack_reset} = '0;
        external_reset_pin_n = 1'b1;
        {paddr, pwdata, wake, current_pc} = '0;
        pstrb = 4'hF;
        osc_mode = OSC_EXT_CLOCK_IO;
        port_a_pins = 8'($urandom);
        err_count = 0;
        check_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        expv = RST_VAL;
        sp = '0;
        top = '0;
        rd_all();
        $display("power-on defaults test done");
        wr_all();
        rd_all();
        apb(1'b1, 8'h02, 32'hFF, r, e);
        chk(e, 1'b1);
        apb(1'b0, 8'(43 * 4), 32'h0, r, e);
        chk(e, 1'b1);
        pstrb <= 4'hE;
        apb(1'b1, 8'h00, 32'h3F, r, e);
        pstrb <= 4'hF;
        apb(1'b1, 8'(IDX_CAN_MIRROR_FIRST * 4), 32'hFF, r, e);
        rd_all();
        $display("write and refusal test done");
        for (int m = 0; m < 8; m++) begin
            osc_mode <= 3'(m);
            port_a_pins <= 8'($urandom);
            foreach (fidx[j]) rd_chk(IDX_PORT_A_LATCH + (j % 3 == 2 ? 8 : j));
        end
        osc_mode <= OSC_EXT_CLOCK_IO;
        $display("oscillator mode test done");
        for (int i = 0; i < 12; i++) begin
            wr1(IDX_CORE_IRQ, $urandom | (i < 6 ? 32'hC0 : 32'h0));
            w = prd_wake_s'(8'($urandom));
            w.by_irq = w.by_irq | (i < 6);
            if (i < 6) w.high_prio = i[0];
            wk(w);
        end
        rd_all();
        $display("wake test done");
        for (int k = 0; k < 4; k++) begin
            wr_all();
            warm(k);
            rd_all();
        end
        wr1(IDX_CORE_IRQ, 32'hC0);
        @(posedge pclk);
        wake <= prd_wake_s'(8'hF0);
        wdt_reset <= 1'b1;
        @(posedge pclk);
        {wake.valid, wdt_reset} <= 2'h0;
        #1;
        chk(vector_out.load, 1'b0);
        chk(push_out.push, 1'b0);
        restore(WARM_MASK);
        sp = '0;
        rd_all();
        $display("warm reset test done");
        wr_all();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        expv = RST_VAL;
        sp = '0;
        top = '0;
        rd_all();
        $display("mid-run power-on test done");
        test_done();
    end
endmodule

bind prd_bank prd_bank_props i_prd_bank_props (.pclk, .presetn, .psel,
    .penable, .paddr, .pready, .pslverr, .external_reset_pin_n, .wdt_reset,
    .reset_instr, .stack_reset, .wake, .current_pc, .vector_out, .push_out,
    .reg_image);

// ---- prd_pkg.sv ----
/*
 * Shared constants and carriers for the peripheral reset-defaults bank.
 * Assumes a single pclk domain and a core that reports wake-up events.
 */
package prd_pkg;

    // ************************************************************
    // Register bank geometry
    // ************************************************************
    localparam int NREG = 36;
    localparam int ADDR_W = 8;
    localparam int PC_W = 21;
    localparam int SP_W = 5;

    // Stored register indices; byte address is index times four
    localparam int IDX_CONV_CFG_TWO = 0;
    localparam int IDX_CC_VALUE_HIGH = 1;
    localparam int IDX_CC_VALUE_LOW = 2;
    localparam int IDX_CC_CONTROL = 3;
    localparam int IDX_ECC_VALUE_HIGH = 4;
    localparam int IDX_ECC_VALUE_LOW = 5;
    localparam int IDX_ECC_CONTROL = 6;
    localparam int IDX_ECC_DEADBAND = 7;
    localparam int IDX_ECC_SHUTDOWN = 8;
    localparam int IDX_CMP_VREF = 9;
    localparam int IDX_CMP_CONTROL = 10;
    localparam int IDX_TMR3_HIGH = 11;
    localparam int IDX_TMR3_LOW = 12;
    localparam int IDX_TMR3_CONTROL = 13;
    localparam int IDX_SER_BAUD = 14;
    localparam int IDX_SER_RX_DATA = 15;
    localparam int IDX_SER_TX_DATA = 16;
    localparam int IDX_SER_TX_STAT = 17;
    localparam int IDX_SER_RX_STAT = 18;
    localparam int IDX_NVM_ADDR = 19;
    localparam int IDX_NVM_DATA = 20;
    localparam int IDX_NVM_UNLOCK = 21;
    localparam int IDX_NVM_CONTROL = 22;
    localparam int IDX_PRIO_THREE = 23;
    localparam int IDX_REQ_THREE = 24;
    localparam int IDX_EN_THREE = 25;
    localparam int IDX_PRIO_TWO = 26;
    localparam int IDX_REQ_TWO = 27;
    localparam int IDX_EN_TWO = 28;
    localparam int IDX_PRIO_ONE = 29;
    localparam int IDX_REQ_ONE = 30;
    localparam int IDX_EN_ONE = 31;
    localparam int IDX_PORT_A_LATCH = 32;
    localparam int IDX_PORT_A_DIR = 33;
    localparam int IDX_CAN_STATUS = 34;
    localparam int IDX_CORE_IRQ = 35;
    // Read-only views
    localparam int IDX_CAN_MIRROR_FIRST = 36;
    localparam int IDX_CAN_MIRROR_LAST = 39;
    localparam int IDX_PORT_A_PINS = 40;
    localparam int IDX_STACK_PTR = 41;
    localparam int IDX_STACK_TOP = 42;
    localparam int IDX_LAST = 42;

    // ************************************************************
    // Per-register reset behaviour
    // ************************************************************
    // Unimplemented bits are forced to zero here
    localparam logic [7:0] IMPL_MASK [NREG] = '{
        8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF7,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'h5F,
        8'h5F, 8'h5F, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hEE, 8'hFF};
    localparam logic [7:0] RST_VAL [NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h5F,
        8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00};
    // Bits restored by pin, watchdog, instruction and stack resets
    localparam logic [7:0] WARM_MASK [NREG] = '{
        8'h3F, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hF7,
        8'hFE, 8'h00, 8'h00, 8'h00, 8'h17, 8'hFF, 8'hFF, 8'hFF, 8'h5F,
        8'h5F, 8'h5F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h7F, 8'h00, 8'hFF};
    // Bits restored by a wake-up from sleep
    localparam logic [7:0] WAKE_MASK [NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // ************************************************************
    // Fields, vectors and modes
    // ************************************************************
    localparam int BIT_HIGH_PRIO_GIE = 7;
    localparam int BIT_LOW_PRIO_GIE = 6;
    localparam int BIT_PORT_A_SHARED = 6;
    localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
    localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
    // Oscillator mode codes are arbitrary choices
    localparam logic [2:0] OSC_EXT_CLOCK_IO = 3'h5;
    localparam logic [2:0] OSC_RC_IO = 3'h7;
    // Wake flag register selector
    localparam logic [1:0] FLAG_CORE = 2'h0;
    localparam logic [1:0] FLAG_REQ_ONE = 2'h1;
    localparam logic [1:0] FLAG_REQ_TWO = 2'h2;
    localparam logic [1:0] FLAG_REQ_THREE = 2'h3;
    localparam int SYNC_STAGES = 3;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic by_irq;
        logic high_prio;
        logic [1:0] flag_reg;
        logic [2:0] flag_bit;
    } prd_wake_s;

    typedef struct packed {
        logic load;
        logic [PC_W-1:0] pc;
    } prd_vector_s;

    typedef struct packed {
        logic push;
        logic [4:0] stack_top_upper;
        logic [7:0] stack_top_high;
        logic [7:0] stack_top_low;
        logic [SP_W-1:0] stack_pointer_reg;
    } prd_push_s;

endpackage

// ---- prd_sync.sv ----
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs arrive from outside the pclk domain.
 */
`timescale 1ns/1ps

module prd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous in, filtered out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] stable
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable <= INIT;
        end else begin
            for (int b = 0; b < W; b++) begin
                if (s2[b] == s3[b]) begin
                    stable[b] <= s3[b];
                end
            end
        end
    end

endmodule
